// ### rtl/sensor_bank_params.svh
// Purpose: Offsets, reset values and timing figures of the sensor register bank.
// Assumes: Offsets are the low address byte; the sensor number sits in address bits 11:8.
// Notes: Definitions only.
`ifndef SENSOR_BANK_PARAMS_SVH
`define SENSOR_BANK_PARAMS_SVH
`define OFF_TRIG_EF 8'h01
`define OFF_RES_A 8'h02
`define OFF_RES_F 8'h07
`define OFF_LED_CTRL 8'h09
`define OFF_DAC_POS_A 8'h0A
`define OFF_DAC_POS_D 8'h0D
`define OFF_DAC_LIM_LO 8'h0E
`define OFF_DAC_LIM_HI 8'h0F
`define OFF_DAC_CTRL 8'h10
`define OFF_KIND 8'h11
`define OFF_IND_CTRL 8'h12
`define KIND_RESET 4'h1
`define WORD_RESET 16'h0000
`define DAC_EN_BIT 7
`define CLK_HZ 25000000
`define LED_HALF_MS 250
`define LED_HALF_CYC ((`CLK_HZ / 1000) * `LED_HALF_MS)
`endif

// ### rtl/sensor_bank_pkg.sv
// Purpose: Types shared by the sensor register bank.
// Assumes: Nothing.
// Notes: Encodings match the documented field codes.
package sensor_bank_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {IND_OFF = 2'h0, IND_ANY = 2'h1, IND_VALID = 2'h2, IND_RSVD = 2'h3} ind_cond_t;
  typedef enum logic [1:0] {ACLR_OFF = 2'h0, ACLR_BEFORE = 2'h1, ACLR_AFTER = 2'h2, ACLR_RSVD = 2'h3} ind_aclr_t;
endpackage

// ### rtl/sensor_channel_register_bank.sv
// Purpose: Per-sensor register bank: trigger flags, results, LED, DAC words, type, sample indicator.
// Assumes: Word port and measurement engine run on sys_clk.
// Notes:
// How it works
// - Trigger register holds eight enables high, eight flags low, reset zero.
// - Host writing zero to a flag clears it.
// - Six read-only result words hold the last finished measurement, reset zero.
// - Types 1 and 4: position, amplitude, frequency, then three unused words.
// - Types 2,6,3: position high, low, fine, coarse, frequency; mismatch for 2,6.
// - Invalid measurement forces the reported position to zero.
// - Position is signed, 65536 counts per sine length.
// - Valid sensor LED pin blinks near 2Hz below threshold, else steady.
// - Four signed position words set rising and falling slope ends.
// - Two unsigned words set lower and upper DAC limits.
// - DAC control word holds enable, output select and operation bits.
// - Bits 15:8 give the DAC value after an invalid measurement.
// - Only sensor 1 type is writable, default 1; others mirror or read zero.
// - Type 4 allows sensors 1 and 2; sensors 3 and 4 read zero.
// - Indicator condition: 0 off, 1 any new, 2 new valid, 3 reserved.
// - Host writing zero to the indicator flag resets it and its pin; here the ind_flag_clr input clears it instead.
// - Indicator auto clear: 0 none, 1 before, 2 after each measurement.
// - Triggers may auto clear without any host traffic.
// - Auto clear removes a trigger during the next measurement.
// - Address bits 11:8 pick the sensor, numbered from 1.
// - Valid flag shows the last measurement had the target in range.
`timescale 1ns/1ps
`include "sensor_bank_params.svh"
module sensor_channel_register_bank
#(
  parameter int unsigned LED_HALF_CYCLES = `LED_HALF_CYC,
  parameter int unsigned NUM_SENSORS = 4
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire sensor_bank_pkg::word_t reg_wdata,
  output sensor_bank_pkg::word_t reg_rdata,
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic [1:0] meas_sensor,
  input wire logic meas_valid,
  input wire logic [31:0] meas_pos32,
  input wire sensor_bank_pkg::word_t meas_amp_a,
  input wire sensor_bank_pkg::word_t meas_amp_b,
  input wire sensor_bank_pkg::word_t meas_rel_freq,
  input wire sensor_bank_pkg::word_t meas_mismatch,
  input wire logic trig_hit,
  input wire logic [1:0] trig_sensor,
  input wire logic [7:0] trig_mask,
  input wire logic [3:0] trig_auto_clear,
  input wire logic [3:0] ind_enable,
  input wire logic [3:0] ind_flag_clr,
  input wire logic [3:0] pin_active_high,
  output logic [31:0] trig_flags,
  output logic [3:0] valid_flags,
  output logic [3:0] ind_flags,
  output logic [3:0] sensor_allowed,
  output logic [3:0] dac_enable,
  output logic [3:0] io_level
);
  import sensor_bank_pkg::*;
  if (NUM_SENSORS != 4 || LED_HALF_CYCLES < 2)
  begin
    $error("Bank serves exactly four sensors and a blink count of at least two.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage and address decode.
  word_t tef_r [4];
  word_t res_r [4][6];
  word_t led_r [4];
  word_t dpos_r [4][4];
  word_t dlim_r [4][2];
  word_t dcw_r [4];
  logic [3:0] sub_r [4];
  logic [3:0] kind_r;
  logic [7:0] sic_r [4];
  logic [3:0] valid_r;
  logic [3:0] ind_r;
  logic blink_r;
  logic [31:0] blink_cnt_r;
  logic [3:0] allowed_r;
  logic [3:0] io_r;

  // Sensor 1..4 in address bits 11:8 maps to storage index 0..3.
  wire [3:0] sensor_no = reg_addr[11:8];
  wire sensor_ok = (sensor_no >= 4'h1) && (sensor_no <= 4'h4);
  wire [1:0] si = 2'(sensor_no - 4'h1);
  wire [7:0] off = reg_addr[7:0];
  wire wr_ok = reg_wr && sensor_ok;

  // Sensors that a given type may measure.
  function automatic logic [2:0] max_sensors(input logic [3:0] kind);
    case (kind)
      4'h1: max_sensors = 3'h4;
      4'h4: max_sensors = 3'h2;
      default: max_sensors = 3'h1;
    endcase
  endfunction

  // Next trigger word: auto clear, then host writes, then new hits, so a hit beats a clear.
  function automatic word_t tef_next(input word_t cur, input logic aclr, input logic wr,
                                     input word_t wd, input logic hit, input logic [7:0] m);
    word_t t;
    t = cur;
    if (aclr)
      t[7:0] = 8'h00;
    if (wr)
    begin
      t[15:8] = wd[15:8];
      t[7:0] = t[7:0] & wd[7:0];
    end
    if (hit)
      t[7:0] = t[7:0] | (m & cur[15:8]);
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Trigger enables and flags; auto clear acts on the start of the next measurement.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int s = 0; s < 4; s++)
        tef_r[s] <= `WORD_RESET;
    end
    else
    begin
      for (int s = 0; s < 4; s++)
        tef_r[s] <= tef_next(tef_r[s],
                             trig_auto_clear[s] && meas_start && meas_sensor == 2'(s),
                             wr_ok && si == 2'(s) && off == `OFF_TRIG_EF,
                             reg_wdata, trig_hit && trig_sensor == 2'(s), trig_mask);
    end
  end

  always_comb
  begin
    for (int s = 0; s < 4; s++)
      trig_flags[8*s +: 8] = tef_r[s][7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results are loaded all at once when a measurement ends.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      valid_r <= 4'h0;
      for (int s = 0; s < 4; s++)
        for (int w = 0; w < 6; w++)
          res_r[s][w] <= `WORD_RESET;
    end
    else if (meas_done)
    begin
      valid_r[meas_sensor] <= meas_valid;
      // Position is 65536 counts per sine length; the 16-bit form wraps with it.
      case (kind_r)
        4'h2, 4'h3, 4'h6:
        begin
          res_r[meas_sensor][0] <= meas_valid ? meas_pos32[31:16] : `WORD_RESET;
          res_r[meas_sensor][1] <= meas_valid ? meas_pos32[15:0] : `WORD_RESET;
          res_r[meas_sensor][2] <= meas_amp_a;
          res_r[meas_sensor][3] <= meas_amp_b;
          res_r[meas_sensor][4] <= meas_rel_freq;
          res_r[meas_sensor][5] <= (kind_r == 4'h3) ? `WORD_RESET : meas_mismatch;
        end
        default:
        begin
          res_r[meas_sensor][0] <= meas_valid ? meas_pos32[15:0] : `WORD_RESET;
          res_r[meas_sensor][1] <= meas_amp_a;
          res_r[meas_sensor][2] <= meas_rel_freq;
          res_r[meas_sensor][3] <= `WORD_RESET;
          res_r[meas_sensor][4] <= `WORD_RESET;
          res_r[meas_sensor][5] <= `WORD_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain read/write configuration words.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      kind_r <= `KIND_RESET;
      for (int s = 0; s < 4; s++)
      begin
        led_r[s] <= `WORD_RESET;
        dcw_r[s] <= `WORD_RESET;
        sub_r[s] <= 4'h0;
        sic_r[s] <= 8'h00;
        for (int k = 0; k < 4; k++)
          dpos_r[s][k] <= `WORD_RESET;
        dlim_r[s][0] <= `WORD_RESET;
        dlim_r[s][1] <= `WORD_RESET;
      end
    end
    else if (wr_ok)
    begin
      if (off == `OFF_LED_CTRL)
        led_r[si] <= reg_wdata;
      if (off >= `OFF_DAC_POS_A && off <= `OFF_DAC_POS_D)
        dpos_r[si][2'(off - `OFF_DAC_POS_A)] <= reg_wdata;
      if (off == `OFF_DAC_LIM_LO)
        dlim_r[si][0] <= reg_wdata;
      if (off == `OFF_DAC_LIM_HI)
        dlim_r[si][1] <= reg_wdata;
      if (off == `OFF_DAC_CTRL)
        dcw_r[si] <= {reg_wdata[15:7], 2'b00, reg_wdata[4:0]};
      if (off == `OFF_KIND)
      begin
        sub_r[si] <= reg_wdata[7:4];
        if (si == 2'h0)
          kind_r <= reg_wdata[3:0];
      end
      if (off == `OFF_IND_CTRL)
        sic_r[si] <= reg_wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample indicator flags.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ind_r <= 4'h0;
    else
    begin
      for (int s = 0; s < 4; s++)
      begin
        logic mine;
        logic set;
        mine = meas_sensor == 2'(s);
        set = meas_done && mine && (ind_cond_t'(sic_r[s][5:4]) == IND_ANY ||
              (ind_cond_t'(sic_r[s][5:4]) == IND_VALID && meas_valid));
        if (set)
          ind_r[s] <= 1'b1;
        else if (ind_flag_clr[s])
          ind_r[s] <= 1'b0;
        else if (meas_start && mine && ind_aclr_t'(sic_r[s][7:6]) == ACLR_BEFORE)
          ind_r[s] <= 1'b0;
        else if (meas_done && mine && ind_aclr_t'(sic_r[s][7:6]) == ACLR_AFTER)
          ind_r[s] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink divider: one toggle every quarter second gives about 2Hz.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
    end
    else if (blink_cnt_r == 32'(LED_HALF_CYCLES - 1))
    begin
      blink_cnt_r <= 32'h0;
      blink_r <= ~blink_r;
    end
    else
      blink_cnt_r <= blink_cnt_r + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Allowed sensors for the current type.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      allowed_r <= 4'h1;
    else
    begin
      for (int s = 0; s < 4; s++)
        allowed_r[s] <= 3'(s) < max_sensors(kind_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User pins: LED and sample indicator activity, then pin polarity.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      io_r <= 4'h0;
    else
    begin
      for (int p = 1; p <= 4; p++)
      begin
        logic act;
        act = 1'b0;
        for (int s = 0; s < 4; s++)
        begin
          word_t amp;
          amp = (kind_r == 4'h1 || kind_r == 4'h4) ? res_r[s][1] : res_r[s][2];
          if (led_r[s][3:0] == 4'(p) && valid_r[s])
            act = act | ((amp < {led_r[s][15:4], 4'h0}) ? blink_r : 1'b1);
          if (sic_r[s][3:0] == 4'(p) && ind_r[s] && ind_enable[s])
            act = 1'b1;
        end
        io_r[p - 1] <= act ? pin_active_high[p - 1] : ~pin_active_high[p - 1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; unmapped addresses return zero.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= `WORD_RESET;
    else if (reg_rd)
    begin
      reg_rdata <= `WORD_RESET;
      if (sensor_ok)
      begin
        case (off) inside
          `OFF_TRIG_EF: reg_rdata <= tef_r[si];
          [`OFF_RES_A:`OFF_RES_F]: reg_rdata <= res_r[si][3'(off - `OFF_RES_A)];
          `OFF_LED_CTRL: reg_rdata <= led_r[si];
          [`OFF_DAC_POS_A:`OFF_DAC_POS_D]: reg_rdata <= dpos_r[si][2'(off - `OFF_DAC_POS_A)];
          `OFF_DAC_LIM_LO: reg_rdata <= dlim_r[si][0];
          `OFF_DAC_LIM_HI: reg_rdata <= dlim_r[si][1];
          `OFF_DAC_CTRL: reg_rdata <= dcw_r[si];
          `OFF_KIND: reg_rdata <= {8'h00, sub_r[si], (si == 2'h0 || allowed_r[si]) ? kind_r : 4'h0};
          `OFF_IND_CTRL: reg_rdata <= {8'h00, sic_r[si]};
        endcase
      end
    end
  end

  // Status outputs straight from flops.
  always_comb
  begin
    valid_flags = valid_r;
    ind_flags = ind_r;
    sensor_allowed = allowed_r;
    io_level = io_r;
    for (int s = 0; s < 4; s++)
      dac_enable[s] = dcw_r[s][`DAC_EN_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on sensor 1 behaviour and on the type 4 sensor allowance.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_done0;
    meas_done && meas_sensor == 2'h0;
  endsequence
  sequence s_start0;
    meas_start && meas_sensor == 2'h0;
  endsequence
  property p_trig_set;
    trig_hit && trig_sensor == 2'h0 && trig_mask[0] && tef_r[0][8] |=> trig_flags[0];
  endproperty
  a_trig_set: assert property (p_trig_set) else $error("Enabled hit did not set flag.");
  property p_trig_clr;
    reg_wr && reg_addr == 12'h101 && !reg_wdata[0] && !trig_hit |=> !trig_flags[0];
  endproperty
  a_trig_clr: assert property (p_trig_clr) else $error("Zero write did not clear flag.");
  property p_auto_clr;
    s_start0 ##0 trig_auto_clear[0] && !trig_hit |=> trig_flags[7:0] == 8'h00;
  endproperty
  a_auto_clr: assert property (p_auto_clr) else $error("Auto clear missed.");
  property p_invalid_zero;
    s_done0 ##0 !meas_valid |=> res_r[0][0] == 16'h0000 && !valid_flags[0];
  endproperty
  a_invalid_zero: assert property (p_invalid_zero) else $error("Invalid position not zero.");
  property p_type1_layout;
    s_done0 ##0 kind_r == 4'h1 |=> res_r[0][1] == $past(meas_amp_a) && res_r[0][3] == 16'h0000;
  endproperty
  a_type1_layout: assert property (p_type1_layout) else $error("Type 1 result layout wrong.");
  property p_kind_locked;
    reg_wr && reg_addr == 12'h211 |=> $stable(kind_r);
  endproperty
  a_kind_locked: assert property (p_kind_locked) else $error("Second sensor changed type.");
  property p_type4_allowed;
    (kind_r == 4'h4) [*2] |-> sensor_allowed == 4'h3;
  endproperty
  a_type4_allowed: assert property (p_type4_allowed) else $error("Type 4 allowance wrong.");
  property p_ind_valid;
    s_done0 ##0 meas_valid && sic_r[0][5:4] == 2'h2 |=> ind_flags[0];
  endproperty
  a_ind_valid: assert property (p_ind_valid) else $error("Indicator not set on valid.");
  property p_ind_before;
    s_start0 ##0 !meas_done && sic_r[0][7:6] == 2'h1 |=> !ind_flags[0];
  endproperty
  a_ind_before: assert property (p_ind_before) else $error("Indicator not cleared before.");
endmodule

// ### bench/host_port_model.sv
// Purpose: Host side of the word register port of the sensor bank.
// Assumes: Requests launch at the falling edge of sys_clk.
// Notes: Read data is taken one cycle after the read strobe.
`timescale 1ns/1ps
module host_port_model
(
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [11:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////
  // Idle port; the data bus never keeps a stale value after a write.
  initial
  begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 12'h000;
    reg_wdata = 16'hA5A5;
  end

  // One-cycle write strobe with address and data held across the edge.
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge sys_clk);
    reg_wr = 1'h0;
    reg_wdata = ~d;
  endtask

  // One-cycle read strobe; the registered answer is settled a cycle later.
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge sys_clk);
    reg_rd = 1'h0;
    d = reg_rdata;
  endtask

  // Sensor kind and subtype go to sensor 1 in a single write.
  task automatic set_kind(input logic [3:0] sub, input logic [3:0] k);
    wr(12'h111, {8'h00, sub, k});
  endtask
endmodule

// ### bench/sensor_channel_register_bank_tb.sv
// Purpose: Self-checking bench of the sensor channel register bank.
// Assumes: Inputs change at the falling edge; blink half period is 4 cycles.
// Notes: Random values come from a fixed seed.
`timescale 1ns/1ps
module sensor_channel_register_bank_tb;
  import sensor_bank_pkg::*;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic reg_wr, reg_rd;
  logic [11:0] reg_addr;
  word_t reg_wdata, reg_rdata, d;
  logic meas_start = 1'h0, meas_done = 1'h0, meas_valid = 1'h0, trig_hit = 1'h0, f;
  logic [1:0] meas_sensor = 2'h0, trig_sensor = 2'h0;
  logic [31:0] meas_pos32 = 32'h0, trig_flags;
  word_t meas_amp_a = 16'h0, meas_amp_b = 16'h0, meas_rel_freq = 16'h0, meas_mismatch = 16'h0;
  logic [7:0] trig_mask = 8'h00, e, m;
  logic [3:0] trig_auto_clear = 4'h0, ind_enable = 4'hF, ind_flag_clr = 4'h0, pin_active_high = 4'h0;
  logic [3:0] valid_flags, ind_flags, sensor_allowed, dac_enable, io_level, k, am, m4, io;
  int err_total = 0, checked = 0, s, i, j, t, tg, off;
  int kinds[8] = '{1, 4, 2, 1, 4, 2, 3, 6};

  // Clock at 25 MHz.
  always #20 sys_clk = ~sys_clk;

  sensor_channel_register_bank #(.LED_HALF_CYCLES(4), .NUM_SENSORS(4)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .meas_start(meas_start), .meas_done(meas_done), .meas_sensor(meas_sensor), .meas_valid(meas_valid),
    .meas_pos32(meas_pos32), .meas_amp_a(meas_amp_a), .meas_amp_b(meas_amp_b), .meas_rel_freq(meas_rel_freq),
    .meas_mismatch(meas_mismatch), .trig_hit(trig_hit), .trig_sensor(trig_sensor), .trig_mask(trig_mask),
    .trig_auto_clear(trig_auto_clear), .ind_enable(ind_enable), .ind_flag_clr(ind_flag_clr),
    .pin_active_high(pin_active_high), .trig_flags(trig_flags), .valid_flags(valid_flags),
    .ind_flags(ind_flags), .sensor_allowed(sensor_allowed), .dac_enable(dac_enable), .io_level(io_level));

  host_port_model host_u (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic end_sim;
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input word_t g, input word_t x);
    checked++;
    if (g !== x)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask

  // Reads a register and compares it.
  task automatic rchk(input logic [11:0] a, input word_t x);
    host_u.rd(a, d);
    chk(d, x);
  endtask

  // One finished measurement with random results and a chosen amplitude.
  task automatic meas(input logic [1:0] sn, input logic v, input word_t amp);
    @(negedge sys_clk);
    meas_sensor = sn;
    meas_valid = v;
    meas_pos32 = $urandom;
    meas_amp_a = amp;
    meas_amp_b = 16'($urandom);
    meas_rel_freq = 16'($urandom);
    meas_mismatch = 16'($urandom);
    meas_done = 1'h1;
    @(negedge sys_clk);
    meas_done = 1'h0;
  endtask

  // One-cycle pulse of trigger hit or measurement start.
  task automatic pulse(input logic hit, input logic [1:0] sn, input logic [7:0] mk);
    @(negedge sys_clk);
    trig_sensor = sn;
    meas_sensor = sn;
    trig_mask = mk;
    trig_hit = hit;
    meas_start = ~hit;
    @(negedge sys_clk);
    trig_hit = 1'h0;
    meas_start = 1'h0;
  endtask

  // Watches pin 2 for 16 cycles: toggles and cycles away from its active level.
  task automatic led_watch(output int tg, output int off);
    logic lv;
    tg = 0;
    off = 0;
    repeat (16)
    begin
      lv = io_level[1];
      @(negedge sys_clk);
      tg += (io_level[1] !== lv);
      off += (io_level[1] !== pin_active_high[1]);
    end
  endtask

  // Expected result word j for sensor kind kk after the last measurement.
  function automatic word_t exp_res(input logic [3:0] kk, input int j);
    logic [31:0] p;
    word_t w[6];
    p = meas_valid ? meas_pos32 : 32'h0;
    if (kk == 4'h1 || kk == 4'h4)
      w = '{p[15:0], meas_amp_a, meas_rel_freq, 16'h0, 16'h0, 16'h0};
    else
      w = '{p[31:16], p[15:0], meas_amp_a, meas_amp_b, meas_rel_freq, (kk == 4'h3) ? 16'h0 : meas_mismatch};
    return w[j];
  endfunction

  // Cuts a hang short.
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    d = 16'($urandom(32'h56013C44));
    pin_active_high = 4'($urandom);
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'h0;
    for (s = 1; s <= 4; s++)
      for (i = 0; i <= 18; i++)
        rchk({s[3:0], i[7:0]}, (i == 17) ? 16'h0001 : 16'h0000);
    host_u.wr(12'h102, 16'hBEEF);
    rchk(12'h102, 16'h0000);
    host_u.wr(12'h50A, 16'h1234);
    rchk(12'h50A, 16'h0000);
    for (i = 9; i <= 16; i++)
    begin
      s = 1 + $urandom % 4;
      d = 16'($urandom);
      host_u.wr({s[3:0], i[7:0]}, d);
      d = (i == 16) ? (d & 16'hFF9F) : d;
      rchk({s[3:0], i[7:0]}, d);
    end
    chk({15'h0, dac_enable[s-1]}, {15'h0, d[7]});
    for (s = 1; s <= 4; s++)
      host_u.wr({s[3:0], 8'h09}, 16'h0000);
    for (t = 0; t < 8; t++)
    begin
      k = kinds[t][3:0];
      host_u.set_kind(4'h0, k);
      @(negedge sys_clk);
      am = (k == 4'h1) ? 4'hF : (k == 4'h4) ? 4'h3 : 4'h1;
      if (t < 3)
      begin
        chk({12'h0, sensor_allowed}, {12'h0, am});
        for (s = 1; s <= 4; s++)
          rchk({s[3:0], 8'h11}, {12'h0, am[s-1] ? k : 4'h0});
      end
      for (i = 0; i < 2 && t >= 3; i++)
      begin
        s = (k == 4'h1 && i > 0) ? $urandom % 4 : 0;
        meas(s[1:0], i[0], 16'($urandom));
        chk({15'h0, valid_flags[s]}, {15'h0, i[0]});
        for (j = 0; j < 6; j++)
          rchk({s[3:0] + 4'h1, 8'h02 + j[7:0]}, exp_res(k, j));
      end
    end
    host_u.wr(12'h211, 16'h0037);
    rchk(12'h211, 16'h0030);
    for (s = 0; s < 4; s++)
    begin
      e = 8'($urandom) | 8'h01; // Trigger 1 stays enabled so the set check fires for sensor 1 whenever m[0] is set.
      m = 8'($urandom);
      host_u.wr({s[3:0] + 4'h1, 8'h01}, {e, 8'h00});
      pulse(1'h1, s[1:0], m);
      chk({8'h0, trig_flags[8*s +: 8]}, {8'h0, e & m});
      rchk({s[3:0] + 4'h1, 8'h01}, {e, e & m});
      host_u.wr({s[3:0] + 4'h1, 8'h01}, {e, 8'h00});
      chk({8'h0, trig_flags[8*s +: 8]}, 16'h0000);
      trig_auto_clear[s] = 1'h1;
      pulse(1'h1, s[1:0], 8'hFF);
      chk({8'h0, trig_flags[8*s +: 8]}, {8'h0, e});
      pulse(1'h0, s[1:0], 8'h00);
      chk({8'h0, trig_flags[8*s +: 8]}, 16'h0000);
      trig_auto_clear[s] = 1'h0;
    end
    for (i = 0; i < 8; i++)
    begin
      m4 = 4'((i * 3) % 8);
      host_u.wr(12'h112, {8'h00, 2'h0, i[1:0], m4});
      meas(2'h0, i[2], 16'h0000);
      f = (i[1:0] == 2'h1) || (i[1:0] == 2'h2 && i[2]);
      chk({15'h0, ind_flags[0]}, {15'h0, f});
      @(negedge sys_clk);
      io = ~pin_active_high;
      if (f && m4 >= 4'h1 && m4 <= 4'h4)
        io[m4-1] = ~io[m4-1];
      chk({12'h0, io_level}, {12'h0, io});
      ind_flag_clr = 4'h1;
      @(negedge sys_clk);
      ind_flag_clr = 4'h0;
      @(negedge sys_clk);
      chk({11'h0, ind_flags[0], io_level}, {11'h0, 1'h0, ~pin_active_high});
    end
    host_u.wr(12'h112, 16'h0050);
    meas(2'h0, 1'h1, 16'h0000);
    chk({15'h0, ind_flags[0]}, 16'h0001);
    pulse(1'h0, 2'h0, 8'h00);
    chk({15'h0, ind_flags[0]}, 16'h0000);
    host_u.wr(12'h112, 16'h00A0);
    meas(2'h0, 1'h1, 16'h0000);
    chk({15'h0, ind_flags[0]}, 16'h0001);
    meas(2'h0, 1'h0, 16'h0000);
    chk({15'h0, ind_flags[0]}, 16'h0000);
    host_u.wr(12'h112, 16'h00D0);
    meas(2'h0, 1'h1, 16'h0000);
    pulse(1'h0, 2'h0, 8'h00);
    chk({15'h0, ind_flags[0]}, 16'h0001);
    host_u.wr(12'h109, 16'hFFF2);
    meas(2'h0, 1'h1, 16'h0010);
    led_watch(tg, off);
    chk({15'h0, tg >= 3 && tg <= 5}, 16'h0001);
    meas(2'h0, 1'h1, 16'hFFF0);
    @(negedge sys_clk);
    led_watch(tg, off);
    chk(16'(tg + off), 16'h0000);
    meas(2'h0, 1'h0, 16'hFFF0);
    @(negedge sys_clk);
    led_watch(tg, off);
    chk(16'(off), 16'h0010);
    end_sim();
  end
endmodule
